// *** logic/sarseq_top.sv ***
/*
 * sar adc track and burst sequencer: tracking, power-up, burst repeat,
 * accumulation, done flag, window compare, 8 and 12 bit options.
 * assumes the analog core answers each bit decision on core_bit_i
 * during convert, and that software starts come from logic on mclk_i.
 */
`timescale 1ns/1ps
module sarseq_top (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire sarseq_pkg::sarseq_cfg_t cfg_i,
    input wire logic sw_start_i,
    input wire logic ext_convert_start_i,
    input wire logic core_bit_i,
    output sarseq_pkg::sarseq_ana_t ana_o,
    output logic convert_busy_bit_o,
    output logic conversion_done_flag_o,
    output logic window_hit_o,
    output logic [7:0] result_high_byte_o,
    output logic [7:0] result_low_byte_o,
    input wire logic done_clear_i
);

    // ****************************************************************
    // synchroniser and start detection
    // ****************************************************************
    logic ext_s1_r;
    logic ext_s2_r;
    logic ext_s3_r;
    logic sar_en;
    logic burst;
    logic [6:0] rpt;
    logic twelve;
    logic ext_rise;
    logic start;

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
            ext_s3_r <= 1'b0;
        end else begin
            ext_s1_r <= ext_convert_start_i;
            ext_s2_r <= ext_s1_r;
            ext_s3_r <= ext_s2_r;
        end
    end

    assign burst = cfg_i.burst_enable;
    assign rpt = sarseq_pkg::rpt_count(cfg_i.accumulator_config_reg[2:0]);
    // twelve-bit on config bit, burst mode and a repeat of four or more
    assign twelve = cfg_i.accumulator_config_reg[sarseq_pkg::TWELVE_BIT_POS]
        && burst && (rpt >= sarseq_pkg::RPT_4);
    assign ext_rise = ext_s2_r && !ext_s3_r;
    assign start = cfg_i.ext_start_select ? ext_rise : sw_start_i;

    // sar clock enable, burst clock rate in burst mode
    sarseq_clkgen u_clkgen (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_i),
        .burst_i(burst),
        .div_i(cfg_i.sar_clk_div),
        .sar_en_o(sar_en)
    );

    // ****************************************************************
    // sequencer
    // ****************************************************************
    typedef enum logic [2:0] {
        S_IDLE,
        S_POWERUP,
        S_TRACK,
        S_EXTWAIT,
        S_CONV,
        S_WAIT
    } sarseq_st_t;

    sarseq_st_t st_r, st_nxt;
    logic [7:0] tcnt_r, tcnt_nxt;
    logic [3:0] bit_r, bit_nxt;
    logic [6:0] done_cnt_r, done_cnt_nxt;
    logic [9:0] code_r, code_nxt;
    logic [sarseq_pkg::ACC_W-1:0] acc_r, acc_nxt;
    logic busy_r, busy_nxt;
    logic done_r, done_nxt;
    logic win_r, win_nxt;
    logic [15:0] res_r, res_nxt;
    logic powered_r, powered_nxt;
    logic [3:0] nbits;
    logic [7:0] track_len;
    logic [9:0] code_fin;
    logic [sarseq_pkg::ACC_W-1:0] sum;
    logic [1:0] phase;

    // eight-bit conversion uses two fewer bit cycles
    assign nbits = cfg_i.eight_bit_enable ? sarseq_pkg::BITS_8
                                          : sarseq_pkg::BITS_10;
    // tracking length; low-power tracking adds three
    always_comb begin
        track_len = burst ? {4'h0, cfg_i.burst_track_time_field} : 8'h00;
        if (cfg_i.low_power_track_select) begin
            track_len = track_len + {4'h0, sarseq_pkg::LP_TRACK_CLKS};
        end
        if (track_len == 8'h00) begin
            track_len = 8'h01;
        end
    end

    // low two bits zero in eight-bit mode
    assign code_fin = cfg_i.eight_bit_enable ? {code_r[9:2], 2'b00}
                                             : code_r;
    assign sum = acc_r + {6'h00, code_fin};
    assign phase = done_cnt_r[1:0];

    always_comb begin
        st_nxt = st_r;
        tcnt_nxt = tcnt_r;
        bit_nxt = bit_r;
        done_cnt_nxt = done_cnt_r;
        code_nxt = code_r;
        acc_nxt = acc_r;
        busy_nxt = busy_r;
        done_nxt = done_r;
        win_nxt = win_r;
        res_nxt = res_r;
        // in burst the idle power follows converter enable
        powered_nxt = burst ? (cfg_i.converter_enable || st_r != S_IDLE)
                            : cfg_i.converter_enable;
        if (done_clear_i) begin
            done_nxt = 1'b0;
        end
        unique case (st_r)
            S_IDLE: begin
                // a start opens one conversion or one burst
                if (start && (burst || cfg_i.converter_enable)) begin
                    busy_nxt = 1'b1;
                    tcnt_nxt = 8'h00;
                    if (cfg_i.ext_start_select && !burst
                        && cfg_i.low_power_track_select) begin
                        st_nxt = S_CONV; // rising edge ends tracking
                        bit_nxt = 4'h0;
                        code_nxt = 10'h000;
                    end else if (burst && !powered_r) begin
                        st_nxt = S_POWERUP;
                    end else if (track_len != 8'h00 &&
                                 (burst || cfg_i.low_power_track_select)) begin
                        st_nxt = S_TRACK;
                    end else begin
                        st_nxt = S_CONV;
                        bit_nxt = 4'h0;
                        code_nxt = 10'h000;
                    end
                end
            end
            S_POWERUP: begin
                if (sar_en) begin
                    tcnt_nxt = tcnt_r + 8'h01;
                    if (tcnt_r >= {4'h0, cfg_i.powerup_time_field}) begin
                        st_nxt = S_TRACK;
                        tcnt_nxt = 8'h00;
                    end
                end
            end
            S_TRACK: begin
                if (sar_en) begin
                    tcnt_nxt = tcnt_r + 8'h01;
                    if (tcnt_r + 8'h01 >= track_len) begin
                        st_nxt = S_CONV;
                        bit_nxt = 4'h0;
                        code_nxt = 10'h000;
                    end
                end
            end
            S_EXTWAIT: begin
                // burst with external start: one per rising edge
                if (ext_rise) begin
                    st_nxt = S_TRACK;
                    tcnt_nxt = 8'h00;
                end
            end
            S_CONV: begin
                if (sar_en) begin
                    bit_nxt = bit_r + 4'h1;
                    code_nxt[4'h9 - bit_r] = core_bit_i;
                    if (bit_r + 4'h1 == nbits) begin
                        st_nxt = S_WAIT;
                    end
                end
            end
            S_WAIT: begin
                // accumulate each sample; count to repeat
                acc_nxt = sum;
                done_cnt_nxt = done_cnt_r + 7'h01;
                if (done_cnt_r + 7'h01 >= rpt) begin
                    // busy falls and done sets together
                    st_nxt = S_IDLE;
                    busy_nxt = 1'b0;
                    done_nxt = 1'b1;
                    res_nxt = sum;
                    // eight-bit single sample: msbs fill the high byte
                    if (cfg_i.eight_bit_enable
                        && rpt == sarseq_pkg::RPT_1) begin
                        res_nxt = {sum[9:2], 8'h00};
                    end
                    acc_nxt = 16'h0000;
                    done_cnt_nxt = 7'h00;
                    win_nxt = (sum > cfg_i.win_gt_limit) ||
                              (sum < cfg_i.win_lt_limit);
                end else if (burst && cfg_i.ext_start_select) begin
                    st_nxt = S_EXTWAIT;
                end else if (burst) begin
                    st_nxt = S_TRACK; // back to back
                    tcnt_nxt = 8'h00;
                end else begin
                    st_nxt = S_IDLE; // wait for next start
                    busy_nxt = 1'b0;
                end
            end
            default: begin
                st_nxt = S_IDLE;
            end
        endcase
        // starts while busy are looked at only in S_EXTWAIT, as burst pin edges
        if (!burst && st_r != S_IDLE && st_r != S_CONV
            && st_r != S_WAIT && st_r != S_TRACK) begin
            st_nxt = S_IDLE; // burst dropped mid-sequence
            busy_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_r <= S_IDLE;
            tcnt_r <= 8'h00;
            bit_r <= 4'h0;
            done_cnt_r <= 7'h00;
            code_r <= 10'h000;
            acc_r <= 16'h0000;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            win_r <= 1'b0;
            res_r <= 16'h0000;
            powered_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            tcnt_r <= tcnt_nxt;
            bit_r <= bit_nxt;
            done_cnt_r <= done_cnt_nxt;
            code_r <= code_nxt;
            acc_r <= acc_nxt;
            busy_r <= busy_nxt;
            done_r <= done_nxt;
            win_r <= win_nxt;
            res_r <= res_nxt;
            powered_r <= powered_nxt;
        end
    end

    // ****************************************************************
    // analog controls, registered
    // ****************************************************************
    sarseq_pkg::sarseq_ana_t ana_r, ana_nxt;

    always_comb begin
        ana_nxt.power_up = powered_nxt || st_nxt != S_IDLE;
        ana_nxt.track = (st_nxt == S_TRACK) ||
            (!burst && !cfg_i.low_power_track_select && st_nxt != S_CONV) ||
            // low-power external tracking follows the low pin
            (!burst && cfg_i.low_power_track_select &&
             cfg_i.ext_start_select && !ext_s2_r && st_nxt == S_IDLE);
        ana_nxt.convert = st_nxt == S_CONV;
        ana_nxt.gain_half = cfg_i.gain_select;
        ana_nxt.eight_bit = cfg_i.eight_bit_enable;
        // reference and element set step per sample
        ana_nxt.ref_sel = twelve ? phase : 2'b00;
        ana_nxt.dem_sel = twelve ? phase + 2'b01 : 2'b00;
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ana_r <= '0;
        end else begin
            ana_r <= ana_nxt;
        end
    end

    // four full codes sum to 4092, sixteen to a 14-bit value
    assign ana_o = ana_r;
    assign convert_busy_bit_o = busy_r;
    assign conversion_done_flag_o = done_r;
    assign window_hit_o = win_r;
    assign result_high_byte_o = res_r[15:8];
    // low byte reads zero in eight-bit single-sample mode
    assign result_low_byte_o = res_r[7:0];

endmodule

// *** logic/sarseq_pkg.sv ***
/*
 * package for the sar adc track and burst sequencer: field widths,
 * encodings, timing counts and the packed carriers between files.
 * assumes nothing beyond a systemverilog compiler.
 */
package sarseq_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int MCLK_MHZ = 200;
    localparam int BURST_CLK_MHZ = 20;
    // burst clock derived from mclk, rounded down to whole cycles
    localparam int BURST_DIV = MCLK_MHZ / BURST_CLK_MHZ;
    localparam logic [7:0] BURST_DIV_C = 8'(BURST_DIV);
    localparam logic [3:0] LP_TRACK_CLKS = 4'h3;
    localparam logic [3:0] BITS_10 = 4'ha;
    localparam logic [3:0] BITS_8 = 4'h8;
    localparam logic [3:0] CONV_EXTRA = 4'h3;
    localparam logic [2:0] BURST_START_GAP = 3'h4;

    // ****************************************************************
    // widths and codes
    // ****************************************************************
    localparam int ACC_W = 16;
    localparam int CODE_W = 10;
    localparam logic [9:0] CODE_MAX = 10'h3ff;
    localparam int TWELVE_BIT_POS = 7;
    localparam logic [7:0] ACC_CFG_RST = 8'h00;
    localparam logic [6:0] RPT_1 = 7'h01;
    localparam logic [6:0] RPT_4 = 7'h04;

    typedef enum logic [2:0] {
        SARSEQ_RPT1,
        SARSEQ_RPT4,
        SARSEQ_RPT8,
        SARSEQ_RPT16,
        SARSEQ_RPT32,
        SARSEQ_RPT64
    } sarseq_rpt_t;

    // control bits from software
    typedef struct packed {
        logic converter_enable;
        logic burst_enable;
        logic low_power_track_select;
        logic ext_start_select;
        logic gain_select;
        logic eight_bit_enable;
        logic [7:0] accumulator_config_reg;
        logic [4:0] sar_clk_div;
        logic [3:0] powerup_time_field;
        logic [3:0] burst_track_time_field;
        logic [ACC_W-1:0] win_gt_limit;
        logic [ACC_W-1:0] win_lt_limit;
    } sarseq_cfg_t;

    // controls to analog core
    typedef struct packed {
        logic power_up;
        logic track;
        logic convert;
        logic gain_half;
        logic eight_bit;
        logic [1:0] ref_sel;
        logic [1:0] dem_sel;
    } sarseq_ana_t;

    // repeat count field decode, out-of-range codes give one conversion
    function automatic logic [6:0] rpt_count(input logic [2:0] f);
        case (f)
            3'h1: rpt_count = 7'h04;
            3'h2: rpt_count = 7'h08;
            3'h3: rpt_count = 7'h10;
            3'h4: rpt_count = 7'h20;
            3'h5: rpt_count = 7'h40;
            default: rpt_count = 7'h01;
        endcase
    endfunction

endpackage

// *** logic/sarseq_clkgen.sv ***
/*
 * sar clock enable generator: one-cycle enable pulses at the sar rate.
 * assumes mclk_i is the only clock; the divided system clock and the
 * burst clock both become enables on it.
 */
`timescale 1ns/1ps
module sarseq_clkgen (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic burst_i,
    input wire logic [4:0] div_i,
    output logic sar_en_o
);

    // ****************************************************************
    // divider
    // ****************************************************************
    logic [7:0] cnt_r;
    logic [7:0] cnt_nxt;
    logic [7:0] limit;
    logic en_r;
    logic en_nxt;

    // in burst mode the divider runs from the burst clock period in place of div_i
    always_comb begin
        limit = burst_i ? sarseq_pkg::BURST_DIV_C - 8'h01 : {3'h0, div_i};
        if (cnt_r >= limit) begin
            cnt_nxt = 8'h00;
            en_nxt = 1'b1;
        end else begin
            cnt_nxt = cnt_r + 8'h01;
            en_nxt = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_r <= 8'h00;
            en_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            en_r <= en_nxt;
        end
    end

    assign sar_en_o = en_r;

endmodule

// *** sim/sarseq_asserts.sv ***
/*
 * checker for sarseq_top: busy, done, result, tracking and power timing.
 * assumes it is bound to sarseq_top and sees only its ports.
 */
`timescale 1ns/1ps
module sarseq_asserts (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire sarseq_pkg::sarseq_cfg_t cfg_i,
    input wire logic sw_start_i,
    input wire sarseq_pkg::sarseq_ana_t ana_o,
    input wire logic convert_busy_bit_o,
    input wire logic conversion_done_flag_o,
    input wire logic window_hit_o,
    input wire logic [7:0] result_high_byte_o,
    input wire logic [7:0] result_low_byte_o
);
    // ****************************************************************
    // sequences and properties
    // ****************************************************************
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_end;
        $fell(convert_busy_bit_o);
    endsequence
    // three idle cycles with steady settings, so registered outputs
    // have caught up with a settings change or a reset release
    sequence s_calm;
        (!convert_busy_bit_o && $stable(cfg_i)) [*3];
    endsequence

    a_done_at_end: assert property (
        s_end ##0 (cfg_i.burst_enable ||
        cfg_i.accumulator_config_reg[2:0] == 3'h0) |-> conversion_done_flag_o)
        else $error("done flag not set when busy fell");
    a_done_cause: assert property (
        $rose(conversion_done_flag_o) |-> $fell(convert_busy_bit_o))
        else $error("done flag rose without end of conversion");
    a_result_hold: assert property (
        !$fell(convert_busy_bit_o) |->
        $stable({result_high_byte_o, result_low_byte_o, window_hit_o}))
        else $error("result or window changed outside completion");
    a_idle_tracks: assert property (
        s_calm ##0 (cfg_i.converter_enable && !cfg_i.burst_enable &&
        !cfg_i.low_power_track_select) |-> ana_o.track)
        else $error("normal mode idle without tracking");
    a_conv_holds: assert property (
        ana_o.convert |-> !ana_o.track && ana_o.power_up)
        else $error("tracking or unpowered during conversion");
    a_burst_sleep: assert property (
        s_calm ##0 (cfg_i.burst_enable && !cfg_i.converter_enable) |->
        !ana_o.power_up)
        else $error("converter left powered after burst");
    a_gain_follow: assert property (
        $stable(cfg_i.gain_select) [*2] |->
        ana_o.gain_half == cfg_i.gain_select)
        else $error("gain control differs from setting");
    a_eight_follow: assert property (
        $stable(cfg_i.eight_bit_enable) [*2] |->
        ana_o.eight_bit == cfg_i.eight_bit_enable)
        else $error("eight bit control differs from setting");
    a_low_zero: assert property (
        s_end ##0 (cfg_i.eight_bit_enable && !cfg_i.burst_enable &&
        cfg_i.accumulator_config_reg[2:0] == 3'h0) |->
        result_low_byte_o == 8'h00)
        else $error("low byte not zero in eight bit mode");
    a_twelve_max: assert property (
        s_end ##0 (cfg_i.burst_enable && cfg_i.accumulator_config_reg[7] &&
        cfg_i.accumulator_config_reg[2:0] == 3'h1) |->
        {result_high_byte_o, result_low_byte_o} <= 16'h0ffc)
        else $error("twelve bit result above full scale");
    a_start_taken: assert property (
        sw_start_i && !cfg_i.ext_start_select && !ana_o.convert &&
        (cfg_i.converter_enable || cfg_i.burst_enable) &&
        !convert_busy_bit_o && !$past(convert_busy_bit_o) |=>
        convert_busy_bit_o)
        else $error("start in idle not taken");
endmodule

// *** sim/sarseq_core_model.sv ***
/*
 * analog core stand-in: the comparator reports a fixed input level.
 * assumes the design samples core_bit_i only while converting.
 */
`timescale 1ns/1ps
module sarseq_core_model (
    input wire logic mclk_i,
    input wire sarseq_pkg::sarseq_ana_t ana_i,
    input wire logic level_i,
    output logic core_bit_o
);
    logic flip_r = 1'b0;
    logic flip_nxt;

    always_comb flip_nxt = ~flip_r;
    always @(posedge mclk_i) flip_r <= flip_nxt;
    // outside a conversion the comparator means nothing, so it toggles
    // instead of holding the last decision
    always_comb core_bit_o = (ana_i.convert && ana_i.power_up) ?
        level_i : flip_r;
endmodule

// *** sim/sarseq_top_test.sv ***
/*
 * bench for sarseq_top: software and pin starts, burst table, 8/12 bit.
 * assumes the package, core model and checker are compiled first.
 */
`timescale 1ns/1ps
module sarseq_top_test;
    logic mclk_i = 1'b0;
    logic rst_n_i = 1'b0;
    sarseq_pkg::sarseq_cfg_t cfg = '0;
    sarseq_pkg::sarseq_ana_t ana;
    logic sw = 1'b0;
    logic pin = 1'b0;
    logic clr = 1'b0;
    logic lvl = 1'b1;
    logic bit_w, busy, done, win, cv_q = 1'b0;
    logic [7:0] hi, lo;
    logic [1:0] dem_q = 2'h0;
    logic [1:0] ref_q = 2'h0;
    int cv_n = 0;
    int num_errors = 0;
    int check_count = 0;
    int n_conv = 0;
    int trk_n = 0;
    int dem_rep = 0;
    int rpt_n[6] = '{1, 4, 8, 16, 32, 64};
    int base, lat, trk, t_on;

    initial forever #2.5 mclk_i = ~mclk_i;

    sarseq_top DUT (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .cfg_i(cfg),
        .sw_start_i(sw), .ext_convert_start_i(pin), .core_bit_i(bit_w),
        .ana_o(ana), .convert_busy_bit_o(busy),
        .conversion_done_flag_o(done), .window_hit_o(win),
        .result_high_byte_o(hi), .result_low_byte_o(lo),
        .done_clear_i(clr));
    sarseq_core_model u_core (.mclk_i(mclk_i), .ana_i(ana),
        .level_i(lvl), .core_bit_o(bit_w));

    // ****************************************************************
    // monitor and tasks
    // ****************************************************************
    always @(negedge mclk_i) begin
        cv_q <= ana.convert;
        if (ana.track === 1'b1) trk_n <= trk_n + 1;
        if (ana.convert === 1'b1) cv_n <= cv_n + 1;
        if (ana.convert === 1'b1 && cv_q === 1'b0) begin
            n_conv <= n_conv + 1;
            dem_q <= ana.dem_sel;
            ref_q <= ana.ref_sel;
            if (ana.dem_sel === dem_q || ana.ref_sel === ref_q)
                dem_rep <= dem_rep + 1;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h not %h", $time, got, exp);
        end
    endtask

    task automatic go(input logic ext);
        int b;
        int t0;
        b = n_conv;
        t0 = trk_n;
        lat = 0;
        @(negedge mclk_i);
        if (ext) pin = 1'b1;
        else sw = 1'b1;
        @(negedge mclk_i);
        sw = 1'b0;
        while (n_conv == b && lat < 20000) begin
            @(posedge mclk_i);
            lat++;
        end
        trk = trk_n - t0;
    endtask

    task automatic fin(input int n, input logic [15:0] msk,
        input logic [15:0] exp);
        int w;
        w = 0;
        while (done !== 1'b1 && w < 30000) begin
            @(negedge mclk_i);
            w++;
        end
        chk(32'(done), 32'h1);
        chk(32'(n_conv - base), 32'(n));
        chk(32'({hi, lo} & msk), 32'(exp));
        @(negedge mclk_i);
        clr = 1'b1;
        @(negedge mclk_i);
        clr = 1'b0;
        base = n_conv;
    endtask

    // a second start mid-run must leave the run untouched
    task automatic one(input int n, input logic [15:0] msk,
        input logic [15:0] exp);
        go(1'b0);
        repeat (6) @(negedge mclk_i);
        sw = 1'b1;
        @(negedge mclk_i);
        sw = 1'b0;
        fin(n, msk, exp);
    endtask

    task automatic end_of_test;
        if (num_errors == 0 && check_count > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge mclk_i);
        num_errors++;
        end_of_test;
    end

    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        cfg.converter_enable = 1'b1;
        cfg.sar_clk_div = 5'h01;
        cfg.powerup_time_field = 4'h2;
        cfg.burst_track_time_field = 4'h2;
        cfg.win_gt_limit = 16'hffff;
        repeat (20) @(posedge mclk_i);
        chk(32'({busy, done, win, hi, lo, ana}), 32'h0);
        @(negedge mclk_i);
        rst_n_i = 1'b1;
        repeat (4) @(negedge mclk_i);
        chk(32'(ana.track), 32'h1);
        base = n_conv;
        one(1, 16'hffff, 16'h03ff);
        chk(32'({win, done}), 32'h0);
        cfg.accumulator_config_reg = 8'h01;
        cfg.win_gt_limit = 16'h0ffb;
        for (int i = 0; i < 4; i++) begin
            go(1'b0);
            repeat (40) @(negedge mclk_i);
            if (i < 3) chk(32'(done), 32'h0);
        end
        fin(4, 16'hffff, 16'h0ffc);
        chk(32'(win), 32'h1);
        lvl = 1'b0;
        cfg.accumulator_config_reg = 8'h00;
        cfg.win_gt_limit = 16'hffff;
        cfg.win_lt_limit = 16'h0001;
        cfg.gain_select = 1'b1;
        one(1, 16'hffff, 16'h0000);
        chk(32'({win, ana.gain_half}), 32'h3);
        lvl = 1'b1;
        cfg.low_power_track_select = 1'b1;
        one(1, 16'hffff, 16'h03ff);
        chk(32'(trk >= 5 && trk <= 8), 32'h1);
        cfg.ext_start_select = 1'b1;
        repeat (4) @(negedge mclk_i);
        chk(32'(ana.track), 32'h1);
        go(1'b1);
        chk(32'(lat <= 8), 32'h1);
        fin(1, 16'hffff, 16'h03ff);
        chk(32'(ana.track), 32'h0);
        pin = 1'b0;
        cfg.low_power_track_select = 1'b0;
        cfg.burst_enable = 1'b1;
        cfg.accumulator_config_reg = 8'h01;
        for (int i = 0; i < 4; i++) begin
            go(1'b1);
            repeat (200) @(negedge mclk_i);
            pin = 1'b0;
            if (i < 3) chk(32'(done), 32'h0);
            repeat (8) @(negedge mclk_i);
        end
        fin(4, 16'hffff, 16'h0ffc);
        cfg.ext_start_select = 1'b0;
        cfg.accumulator_config_reg = 8'h00;
        one(1, 16'hffff, 16'h03ff);
        chk(32'(ana.power_up), 32'h1);
        t_on = lat;
        cfg.converter_enable = 1'b0;
        for (int k = 0; k < 6; k++) begin
            cfg.accumulator_config_reg = 8'(k);
            one(rpt_n[k], 16'hffff, 16'(16'h03ff * rpt_n[k]));
            if (k == 0) chk(32'(lat >= t_on + 20), 32'h1);
            repeat (4) @(negedge mclk_i);
            chk(32'(ana.power_up), 32'h0);
        end
        cfg.converter_enable = 1'b1;
        t_on = dem_rep;
        cfg.accumulator_config_reg = 8'h81;
        one(4, 16'hffff, 16'h0ffc);
        cfg.accumulator_config_reg = 8'h83;
        one(16, 16'hffff, 16'h3ff0);
        chk(32'(dem_rep - t_on <= 2), 32'h1);
        cfg.burst_enable = 1'b0;
        cfg.accumulator_config_reg = 8'h00;
        cfg.eight_bit_enable = 1'b1;
        t_on = cv_n;
        one(1, 16'hffff, 16'hff00);
        chk(32'(cv_n - t_on <= 16), 32'h1);
        chk(32'(ana.eight_bit), 32'h1);
        cfg.converter_enable = 1'b0;
        @(negedge mclk_i);
        sw = 1'b1;
        @(negedge mclk_i);
        sw = 1'b0;
        repeat (10) @(negedge mclk_i);
        chk(32'(busy), 32'h0);
        end_of_test;
    end
endmodule

bind sarseq_top sarseq_asserts u_chk (
    .mclk_i(mclk_i),
    .rst_n_i(rst_n_i),
    .cfg_i(cfg_i),
    .sw_start_i(sw_start_i),
    .ana_o(ana_o),
    .convert_busy_bit_o(convert_busy_bit_o),
    .conversion_done_flag_o(conversion_done_flag_o),
    .window_hit_o(window_hit_o),
    .result_high_byte_o(result_high_byte_o),
    .result_low_byte_o(result_low_byte_o)
);
